// ==== hdl/bps_pkg.sv ====
package bps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RST_SEQ_MIN_US = 15;
  localparam int unsigned RST_SEQ_MAX_US = 150;
  localparam int unsigned RST_SEQ_MIN_CYC = (RST_SEQ_MIN_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned RST_SEQ_MAX_CYC = (RST_SEQ_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SEQ_CW = 11;
  localparam logic [SEQ_CW-1:0] SEQ_LAST = SEQ_CW'(RST_SEQ_MIN_CYC - 1);
  localparam int unsigned REF_CLK_MHZ = 100;
  localparam int unsigned REF_DIV = (1000 / CLK_PERIOD_NS) / REF_CLK_MHZ;
  localparam logic [7:0] REF_LAST = 8'(REF_DIV - 1);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW = 12;
  localparam logic [APB_AW-1:0] PLL_CFG_ADDR = 12'h000;
  localparam logic [APB_AW-1:0] BOOT_STAT_ADDR = 12'h004;
  localparam int unsigned F_LSB = 0;
  localparam int unsigned F_W = 12;
  localparam int unsigned R_LSB = 12;
  localparam int unsigned R_W = 6;
  localparam int unsigned OUTDIV_LSB = 20;
  localparam int unsigned OUTDIV_W = 3;
  localparam int unsigned STATE_LSB = 0;
  localparam int unsigned RUN_BIT = 4;
  localparam int unsigned ERR_BIT = 5;
  localparam int unsigned OTP_BIT = 6;
  localparam int unsigned STRAP_LSB = 8;

  // ----------------------------------------------------------------
  // Synthesiser defaults
  // ----------------------------------------------------------------
  localparam logic [OUTDIV_W-1:0] OUTDIV_DEF = 3'h1;
  localparam logic [R_W-1:0] R_DEF = 6'h00;
  localparam logic [F_W-1:0] F_RATIO40 = 12'h09F;
  localparam logic [F_W-1:0] F_RATIO16 = 12'h03F;
  localparam logic [F_W-1:0] F_RATIO8 = 12'h01F;
  localparam logic [F_W-1:0] F_RATIO4 = 12'h00F;
  localparam int unsigned SECURE_BOOT_BIT = 5;

  // ----------------------------------------------------------------
  // Image check
  // ----------------------------------------------------------------
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam logic [1:0] BYTE_LAST = 2'h3;

  typedef enum logic [2:0] {
    ST_SEQ = 3'b000,
    ST_LEN = 3'b001,
    ST_PROG = 3'b010,
    ST_CRC = 3'b011,
    ST_CHECK = 3'b100,
    ST_RUN = 3'b101,
    ST_ERR = 3'b110
  } bps_state_e;

  function automatic logic [F_W-1:0] bps_strap_f(input logic [1:0] strap);
    case (strap)
      2'b00: return F_RATIO40;
      2'b11: return F_RATIO16;
      2'b10: return F_RATIO8;
      default: return F_RATIO4;
    endcase
  endfunction

endpackage

// ==== hdl/bps_crc32.sv ====
module bps_crc32 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic init,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [31:0] crc_q
);
  import bps_pkg::*;

  // ----------------------------------------------------------------
  // Byte update
  // ----------------------------------------------------------------
  function automatic logic [31:0] bps_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ d[i])
        r = (r >> 1) ^ CRC_POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction

  wire [31:0] crc_d = init ? CRC_INIT : (en ? bps_crc_byte(crc_q, data) : crc_q);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      crc_q <= CRC_INIT;
    else
      crc_q <= crc_d;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_crc_init_ones: assert property (@(posedge clk) disable iff (!rst_b)
    init |=> crc_q == CRC_INIT)
    else $error("crc not reloaded with all ones");
  a_crc_hold_idle: assert property (@(posedge clk) disable iff (!rst_b)
    (!init && !en) |=> $stable(crc_q))
    else $error("crc changed without a byte");

endmodule

// ==== hdl/bps_boot_seq.sv ====
module bps_boot_seq #(
  parameter int unsigned RAM_AW = 16,
  parameter int unsigned SEQ_MAX_CYC = bps_pkg::RST_SEQ_MAX_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ratio_strap_pin_0,
  input wire logic ratio_strap_pin_1,
  input wire logic [31:0] security_word,
  input wire logic [bps_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  output logic gpio_pulldown_en_q,
  output logic core_run_q,
  output logic [31:0] exec_addr_q,
  output logic boot_error_q,
  output logic [bps_pkg::F_W-1:0] pll_feedback_q,
  output logic [bps_pkg::R_W-1:0] pll_ref_div_q,
  output logic [bps_pkg::OUTDIV_W-1:0] output_divider_q,
  output logic tile_ref_tick_q,
  output logic src_req_q,
  output logic src_otp_q,
  output logic [31:0] src_addr_q,
  input wire logic [7:0] src_data,
  input wire logic src_valid,
  output logic ram_we_q,
  output logic [RAM_AW-1:0] ram_addr_q,
  output logic [31:0] ram_wdata_q
);
  import bps_pkg::*;

  bps_state_e state_q;
  bps_state_e state_d;
  logic [SEQ_CW-1:0] seq_cnt_q;
  logic strap_taken_q;
  logic [1:0] strap_q;
  logic [1:0] bcnt_q;
  logic [23:0] sh_q;
  logic [31:0] len_q;
  logic [31:0] wcnt_q;
  logic [31:0] chk_q;
  logic [7:0] ref_cnt_q;
  logic [31:0] crc_w;
  logic [31:0] stat_w;

  // ----------------------------------------------------------------
  // Byte stream decode
  // ----------------------------------------------------------------
  wire [1:0] strap_w = {ratio_strap_pin_1, ratio_strap_pin_0};
  wire take = src_req_q & src_valid;
  wire [31:0] word_w = {src_data, sh_q};
  wire word_done = take & (bcnt_q == BYTE_LAST);
  wire [31:0] wcnt_inc = wcnt_q + 32'h1;
  wire crc_en = take & ((state_q == ST_LEN) | (state_q == ST_PROG));
  wire crc_skip = chk_q == CRC_SKIP;
  wire crc_ok = crc_skip | (chk_q == ~crc_w);
  wire fetch_d = (state_d == ST_LEN) | (state_d == ST_PROG) | (state_d == ST_CRC);
  wire ram_we_d = word_done & (state_q == ST_PROG);

  bps_crc32 u_crc (
    .clk(clk),
    .rst_b(rst_b),
    .init(state_q == ST_SEQ),
    .en(crc_en),
    .data(src_data),
    .crc_q(crc_w)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_SEQ:
        if (strap_taken_q && seq_cnt_q == SEQ_LAST)
          state_d = ST_LEN;
      ST_LEN:
        if (word_done)
          state_d = (word_w == 32'h0) ? ST_CRC : ST_PROG;
      ST_PROG:
        if (word_done && wcnt_inc == len_q)
          state_d = ST_CRC;
      ST_CRC:
        if (word_done)
          state_d = ST_CHECK;
      ST_CHECK:
        state_d = crc_ok ? ST_RUN : ST_ERR;
      ST_RUN:
        state_d = ST_RUN;
      ST_ERR:
        state_d = ST_ERR;
      default:
        state_d = ST_SEQ;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ST_SEQ;
      seq_cnt_q <= '0;
      gpio_pulldown_en_q <= 1'b1;
      core_run_q <= 1'b0;
      boot_error_q <= 1'b0;
      exec_addr_q <= 32'h0;
    end
    else
    begin
      state_q <= state_d;
      gpio_pulldown_en_q <= 1'b0;
      if (state_q == ST_SEQ && strap_taken_q)
        seq_cnt_q <= seq_cnt_q + SEQ_CW'(1);
      core_run_q <= state_d == ST_RUN;
      boot_error_q <= state_d == ST_ERR;
      exec_addr_q <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Straps and security sampled once after release
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_taken_q <= 1'b0;
      strap_q <= 2'b00;
      src_otp_q <= 1'b0;
    end
    else if (!strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      strap_q <= strap_w;
      src_otp_q <= security_word[SECURE_BOOT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Image fetch and RAM load
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_req_q <= 1'b0;
      src_addr_q <= 32'h0;
      bcnt_q <= 2'h0;
      sh_q <= 24'h0;
      len_q <= 32'h0;
      wcnt_q <= 32'h0;
      chk_q <= 32'h0;
      ram_we_q <= 1'b0;
      ram_addr_q <= '0;
      ram_wdata_q <= 32'h0;
    end
    else
    begin
      src_req_q <= fetch_d;
      ram_we_q <= ram_we_d;
      if (take)
      begin
        src_addr_q <= src_addr_q + 32'h1;
        bcnt_q <= bcnt_q + 2'h1;
        sh_q <= word_w[31:8];
      end
      if (word_done && state_q == ST_LEN)
        len_q <= word_w;
      if (word_done && state_q == ST_CRC)
        chk_q <= word_w;
      if (ram_we_d)
      begin
        wcnt_q <= wcnt_inc;
        ram_addr_q <= wcnt_q[RAM_AW-1:0];
        ram_wdata_q <= word_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // Synthesiser settings and reference tick
  // ----------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_acc = psel & penable & pready_q;
  wire hit_pll = paddr == PLL_CFG_ADDR;
  wire hit_stat = paddr == BOOT_STAT_ADDR;
  wire pll_wr = apb_acc & pwrite & hit_pll & strap_taken_q;
  wire [31:0] pll_w = {{(32 - OUTDIV_LSB - OUTDIV_W){1'b0}}, output_divider_q,
                       {(OUTDIV_LSB - R_LSB - R_W){1'b0}},
                       pll_ref_div_q, pll_feedback_q};
  wire [31:0] rd_w = hit_pll ? pll_w : (hit_stat ? stat_w : 32'h0);

  always_comb
  begin
    stat_w = 32'h0;
    stat_w[STATE_LSB +: 3] = state_q;
    stat_w[RUN_BIT] = core_run_q;
    stat_w[ERR_BIT] = boot_error_q;
    stat_w[OTP_BIT] = src_otp_q;
    stat_w[STRAP_LSB +: 2] = strap_q;
  end

  // Tile clock = osc * (F+1)/2 / (R+1) / (div+1), formed outside from these
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pll_feedback_q <= F_RATIO40;
      pll_ref_div_q <= R_DEF;
      output_divider_q <= OUTDIV_DEF;
    end
    else if (!strap_taken_q)
    begin
      pll_feedback_q <= bps_strap_f(strap_w);
      pll_ref_div_q <= R_DEF;
      output_divider_q <= OUTDIV_DEF;
    end
    else if (pll_wr)
    begin
      pll_feedback_q <= pwdata[F_LSB +: F_W];
      pll_ref_div_q <= pwdata[R_LSB +: R_W];
      output_divider_q <= pwdata[OUTDIV_LSB +: OUTDIV_W];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_cnt_q <= 8'h0;
      tile_ref_tick_q <= 1'b0;
    end
    else
    begin
      ref_cnt_q <= (ref_cnt_q == REF_LAST) ? 8'h0 : ref_cnt_q + 8'h1;
      tile_ref_tick_q <= ref_cnt_q == REF_LAST;
    end
  end

  // ----------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= apb_setup;
      pslverr_q <= apb_setup & ~(hit_pll | hit_stat);
      if (apb_setup)
        prdata_q <= pwrite ? 32'h0 : rd_w;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_seq_window: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(state_q) == ST_SEQ && state_q == ST_LEN) |->
      ($past(seq_cnt_q) + 1 >= RST_SEQ_MIN_CYC) && ($past(seq_cnt_q) + 1 <= SEQ_MAX_CYC))
    else $error("boot start outside the reset sequence window");
  a_pulldown_drop: assert property (@(posedge clk) disable iff (!rst_b)
    gpio_pulldown_en_q |-> !strap_taken_q && !core_run_q ##1 !gpio_pulldown_en_q)
    else $error("pull-downs not tied to reset");
  a_strap_default: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(strap_taken_q) |-> pll_feedback_q == bps_strap_f($past(strap_w))
      && pll_ref_div_q == R_DEF && output_divider_q == OUTDIV_DEF)
    else $error("strap defaults wrong");
  a_pll_write: assert property (@(posedge clk) disable iff (!rst_b)
    pll_wr |=> pll_feedback_q == $past(pwdata[F_LSB +: F_W])
      && output_divider_q == $past(pwdata[OUTDIV_LSB +: OUTDIV_W]))
    else $error("synthesiser write lost");
  a_src_select: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(src_req_q) |-> src_otp_q == security_word[SECURE_BOOT_BIT] && src_addr_q == 32'h0)
    else $error("boot source changed at fetch start");
  a_crc_mismatch: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_CHECK && !crc_skip && chk_q != ~crc_w) |=>
      boot_error_q && !core_run_q ##1 boot_error_q && !core_run_q)
    else $error("bad image started");
  a_skip_run: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_CHECK && crc_skip) |=> core_run_q && exec_addr_q == 32'h0)
    else $error("skip value did not start program");
  a_ram_order: assert property (@(posedge clk) disable iff (!rst_b)
    ram_we_q |-> 32'(ram_addr_q) == ((wcnt_q - 32'h1) & ((32'h1 << RAM_AW) - 32'h1)))
    else $error("ram word address out of order");
  a_len_first: assert property (@(posedge clk) disable iff (!rst_b)
    ($past(state_q) == ST_LEN && state_q == ST_PROG) |-> len_q != 32'h0 && wcnt_q == 32'h0)
    else $error("length word not taken first");
  a_apb_ready: assert property (@(posedge clk) disable iff (!rst_b)
    apb_setup |=> pready_q ##1 !pready_q)
    else $error("apb ready timing wrong");

  c_boot_run: cover property (@(posedge clk) disable iff (!rst_b) $rose(core_run_q));
  c_boot_err: cover property (@(posedge clk) disable iff (!rst_b) $rose(boot_error_q));
  c_boot_skip: cover property (@(posedge clk) disable iff (!rst_b)
    state_q == ST_CHECK && crc_skip);
  c_pll_write: cover property (@(posedge clk) disable iff (!rst_b) pll_wr);

endmodule

// ==== dv/bps_flash_model.sv ====
module bps_flash_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fast,
  input wire logic src_req_q,
  input wire logic [31:0] src_addr_q,
  output logic src_valid,
  output logic [7:0] src_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Byte source: flash or OTP image
  // ----------------------------------------------------------------
  logic [7:0] img [0:63];
  logic valid_q;
  logic [7:0] byte_w;
  // Image served from offset 0 through the tile ports
  assign byte_w = img[src_addr_q[5:0]];
  // Off offer the line shows the inverse, never a stale byte
  assign src_valid = valid_q;
  assign src_data = valid_q ? byte_w : ~byte_w;
  // Slow mode idles one cycle after each byte taken
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      valid_q <= 1'b0;
    else
      valid_q <= fast | !(valid_q & src_req_q);
  end
endmodule

// ==== dv/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bps_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ratio_strap_pin_0 = 1'b0;
  logic ratio_strap_pin_1 = 1'b0;
  logic [31:0] security_word = 32'h0;
  logic [APB_AW-1:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic fast = 1'b1;
  logic [31:0] prdata_q, exec_addr_q, src_addr_q, ram_wdata_q;
  logic pready_q, pslverr_q, gpio_pulldown_en_q, core_run_q, boot_error_q;
  logic tile_ref_tick_q, src_req_q, src_otp_q, src_valid, ram_we_q;
  logic [F_W-1:0] pll_feedback_q;
  logic [R_W-1:0] pll_ref_div_q;
  logic [OUTDIV_W-1:0] output_divider_q;
  logic [7:0] src_data;
  logic [15:0] ram_addr_q;
  logic [15:0] wa [$];
  logic [31:0] wd [$];
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end

  bps_boot_seq #(.RAM_AW(16), .SEQ_MAX_CYC(RST_SEQ_MAX_CYC)) DUT (
    .clk, .rst_b, .ratio_strap_pin_0, .ratio_strap_pin_1, .security_word,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata_q, .pready_q, .pslverr_q,
    .gpio_pulldown_en_q, .core_run_q, .exec_addr_q, .boot_error_q,
    .pll_feedback_q, .pll_ref_div_q, .output_divider_q, .tile_ref_tick_q,
    .src_req_q, .src_otp_q, .src_addr_q, .src_data, .src_valid,
    .ram_we_q, .ram_addr_q, .ram_wdata_q
  );
  bps_flash_model fm (.clk, .rst_b, .fast, .src_req_q, .src_addr_q, .src_valid, .src_data);

  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  always @(negedge clk)
  begin
    if (ram_we_q === 1'b1)
    begin
      wa.push_back(ram_addr_q);
      wd.push_back(ram_wdata_q);
    end
  end
  // ----------------------------------------------------------------
  // Bus cycles and helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h0, b};
    for (int k = 0; k < 8; k++)
      r = r[0] ? (r >> 1) ^ 32'hEDB88320 : r >> 1;
    return r;
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wdat,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wdat;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] st, input logic [31:0] sw);
    @(posedge clk);
    rst_b <= 1'b0;
    ratio_strap_pin_1 <= st[1];
    ratio_strap_pin_0 <= st[0];
    security_word <= sw;
    repeat (12) @(posedge clk);
    `CHK(gpio_pulldown_en_q, 1'b1)
    `CHK(core_run_q, 1'b0)
    rst_b <= 1'b1;
    wa.delete();
    wd.delete();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic strap_test();
    logic [F_W-1:0] ef [4] = '{12'h09F, 12'h00F, 12'h01F, 12'h03F};
    int ratio [4] = '{40, 4, 8, 16};
    for (int p = 0; p < 4; p++)
    begin
      do_reset(2'(p), 32'h0);
      repeat (3) @(negedge clk);
      `CHK(gpio_pulldown_en_q, 1'b0)
      `CHK(pll_feedback_q, ef[p])
      `CHK(pll_ref_div_q, 6'h00)
      `CHK(output_divider_q, 3'h1)
      `CHK((pll_feedback_q + 1) / (2 * (output_divider_q + 1)), ratio[p])
      `CHK(tile_ref_tick_q, 1'b1)
    end
    $display("test straps done");
  endtask
  task automatic boot(input int len, input int mode, input logic otp, input logic fst);
    logic [31:0] w [$];
    logic [31:0] crc;
    int n;
    w.push_back(32'(len));
    for (int i = 0; i < len; i++)
      w.push_back(32'hA5C30F00 + 32'(i) * 32'h01020304);
    crc = 32'hFFFFFFFF;
    foreach (w[i])
      for (int b = 0; b < 4; b++)
        crc = crc_step(crc, w[i][8*b+:8]);
    w.push_back(mode == 2 ? 32'h0D15AB1E : ~crc ^ 32'(mode == 1));
    foreach (w[i])
      for (int b = 0; b < 4; b++)
        fm.img[4*i+b] = w[i][8*b+:8];
    fast <= fst;
    do_reset(2'b00, {26'h0, otp, 5'h0});
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (src_req_q !== 1'b1 && n < 16000);
    `CHK(n >= 1500 && n <= 15000, 1'b1)
    `CHK(src_otp_q, otp)
    `CHK(src_addr_q, 32'h0)
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (core_run_q !== 1'b1 && boot_error_q !== 1'b1 && n < 400);
    @(negedge clk);
    `CHK(core_run_q, mode != 1)
    `CHK(boot_error_q, mode == 1)
    `CHK(exec_addr_q, 32'h0)
    `CHK(wa.size(), len)
    for (int i = 0; i < len && i < wa.size(); i++)
    begin
      `CHK(wa[i], 16'(i))
      `CHK(wd[i], w[i+1])
    end
    $display("test boot len %0d mode %0d done", len, mode);
  endtask
  task automatic reg_test();
    logic [31:0] rd;
    logic er;
    // VCO 1250 MHz, tile clock about 417 MHz from the 100 MHz reference
    apb(1'b1, PLL_CFG_ADDR, 32'h002070C7, rd, er);
    `CHK(er, 1'b0)
    @(negedge clk);
    `CHK(pll_feedback_q, 12'h0C7)
    `CHK(pll_ref_div_q, 6'h07)
    `CHK(output_divider_q, 3'h2)
    apb(1'b0, PLL_CFG_ADDR, 32'h0, rd, er);
    `CHK(rd, 32'h002070C7)
    apb(1'b1, BOOT_STAT_ADDR, 32'hFFFFFFFF, rd, er);
    `CHK(er, 1'b0)
    apb(1'b0, BOOT_STAT_ADDR, 32'h0, rd, er);
    `CHK(rd[9:0], 10'h015)
    apb(1'b1, 12'h008, 32'h00000001, rd, er);
    `CHK(er, 1'b1)
    `CHK(pll_feedback_q, 12'h0C7)
    apb(1'b0, 12'h008, 32'h0, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0})
    $display("test registers done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    strap_test();
    boot(0, 0, 1'b0, 1'b1);
    boot(2, 1, 1'b0, 1'b0);
    boot(1, 2, 1'b1, 1'b0);
    boot(3, 0, 1'b0, 1'b0);
    reg_test();
    finish_test();
  end
endmodule
